// ### dv/spi_error_control_bench.sv
// Bench for the serial block: register tasks, a far-end target, and a
// bit-banged controller in the bench for target-mode traffic.
// Assumes read data one cycle after the read strobe.
module spi_error_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_error_control_pkg::*;
  localparam logic [2:0] RCODE [6] = '{3'b100, 3'b000, 3'b001,
                                       3'b110, 3'b010, 3'b011};
  localparam int         RDIV  [6] = '{4, 8, 16, 32, 64, 128};
  logic       clk_sys;
  logic       rst;
  bus_req_s   bus_req;
  logic [7:0] rdata;
  pins_in_s   pins_in;
  pins_out_s  pins_out;
  logic       halt_mode;
  logic       irq;
  logic       wake;
  logic       ss_n;
  logic       sck_m;
  logic       mosi_m;
  logic       sel_p;
  logic       miso_p;
  logic [7:0] tx_p;
  logic [7:0] rx_p;
  logic [7:0] got;
  int         error_cnt;
  int         n_tests;
  int         cyc = 0;

  // Wire levels: an enabled driver wins, else the bench side
  assign pins_in = {pins_out.sck_oe ? pins_out.sck_o : sck_m,
                    pins_out.mosi_oe ? pins_out.mosi_o : mosi_m,
                    pins_out.miso_oe ? pins_out.miso_o : miso_p, ss_n};

  spi_error_control i_spi_error_control (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .bus_req   (bus_req),
    .rdata     (rdata),
    .pins_in   (pins_in),
    .pins_out  (pins_out),
    .halt_mode (halt_mode),
    .irq       (irq),
    .wake      (wake)
  );

  spi_far_end i_spi_far_end (
    .sck     (pins_in.sck),
    .mosi    (pins_in.mosi),
    .sel_n   (sel_p),
    .miso    (miso_p),
    .clock_idle_level    (1'b0),
    .tx_byte (tx_p),
    .rx_byte (rx_p)
  );

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Hang guard, several times the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.we <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.re <= 1'b0;
    @(negedge clk_sys);
    check(nm, e, rdata);
  endtask

  // Cycles until the serial clock output next changes
  task automatic edge_gap(output int n);
    logic s;
    s = pins_out.sck_o;
    n = 0;
    while (pins_out.sck_o === s && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  // One controller byte at rate code c; the far end answers with the inverted byte
  task automatic xfer(input logic [2:0] c, input int h,
                      input logic [7:0] d, input logic col);
    int n;
    tx_p = ~d;
    sel_p <= 1'b0;
    wr(ADDR_CTRL, {2'b11, c[2], 1'b1, 2'b00, c[1:0]});
    wr(ADDR_DATA, d);
    if (col) wr(ADDR_DATA, ~d);
    edge_gap(n);
    edge_gap(n);
    check("half_period", 8'(h), 8'(n));
    if (col) check("irq_on_write_collision_flag", 8'h00, {7'h00, irq});
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    check("irq_done", 8'h01, {7'h00, irq});
    rd(ADDR_CSR, col ? 8'hc0 : 8'h80, "status");
    rd(ADDR_DATA, ~d, "rx_byte");
    sel_p <= 1'b1;
    @(negedge clk_sys);
    check("far_rx", d, rx_p);
    rd(ADDR_CSR, 8'h00, "status_clear");
  endtask

  // Bench as controller, idle low, capture on the leading edge
  task automatic send(input logic [7:0] b, output logic [7:0] g);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_sys);
      mosi_m <= b[i];
      repeat (7) @(posedge clk_sys);
      @(negedge clk_sys);
      g[i] = pins_in.miso;
      @(posedge clk_sys);
      sck_m <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sck_m <= 1'b0;
    end
    @(posedge clk_sys);
    mosi_m <= ~mosi_m;
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    rst = 1'b1;
    bus_req = '0;
    halt_mode = 1'b0;
    ss_n = 1'b1;
    sck_m = 1'b0;
    mosi_m = 1'b0;
    sel_p = 1'b1;
    tx_p = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_CTRL, 8'h00, "ctrl_reset");
    rd(ADDR_CSR, 8'h00, "status_reset");
    $display("test reset done");
    // The six rate codes of RCODE, a collision on the second
    for (int i = 0; i < 6; i++) begin
      xfer(RCODE[i], RDIV[i] / 2, 8'ha5 + 8'(i), i == 1);
    end
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    repeat (3) @(posedge clk_sys);
    check("sck_idle", 8'h01, {7'h00, pins_out.sck_o});
    wr(ADDR_CTRL, 8'h00);
    $display("test controller done");
    wr(ADDR_CTRL, 8'hd0);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check("irq_fault", 8'h01, {7'h00, irq});
    rd(ADDR_CSR, 8'h10, "status_fault");
    rd(ADDR_CTRL, 8'h80, "ctrl_fault");
    ss_n <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CSR, 8'h00, "status_fault_clr");
    $display("test fault done");
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_DATA, 8'h3c);
    @(posedge clk_sys);
    ss_n <= 1'b0;
    send(8'h96, got);
    check("target_tx", 8'h3c, got);
    check("irq_masked", 8'h00, {7'h00, irq});
    wr(ADDR_CTRL, 8'hc0);
    repeat (3) @(posedge clk_sys);
    check("irq_unmasked", 8'h01, {7'h00, irq});
    send(8'h69, got);
    rd(ADDR_CSR, 8'ha0, "status_ovr");
    rd(ADDR_CSR, 8'h80, "status_ovr_clr");
    rd(ADDR_DATA, 8'h96, "kept_byte");
    rd(ADDR_CSR, 8'h00, "status_idle");
    $display("test overrun done");
    @(posedge clk_sys);
    halt_mode <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    send(8'h11, got);
    check("wake", 8'h01, {7'h00, wake});
    send(8'h22, got);
    halt_mode <= 1'b0;
    rd(ADDR_CTRL, 8'hc0, "ctrl_held");
    rd(ADDR_CSR, 8'ha0, "status_halt_ovr");
    rd(ADDR_DATA, 8'h11, "halt_byte");
    send(8'h5a, got);
    rd(ADDR_CSR, 8'h80, "status_extra");
    rd(ADDR_DATA, 8'h5a, "extra_byte");
    @(posedge clk_sys);
    ss_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    halt_mode <= 1'b1;
    @(posedge clk_sys);
    ss_n <= 1'b0;
    send(8'h44, got);
    check("wake_unselected", 8'h00, {7'h00, wake});
    halt_mode <= 1'b0;
    ss_n <= 1'b1;
    rd(ADDR_CSR, 8'h00, "status_frozen");
    $display("test halt done");
    complete_run();
  end
endmodule

// ### dv/spi_far_end.sv
// Far-end target for the serial link, capture on the leading edge.
// Assumes the controller frames each byte with its select held low.
module spi_far_end (
  // Pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output      logic       miso,
  // Setup and capture
  input  wire logic       clock_idle_level,
  input  wire logic [7:0] tx_byte,
  output      logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  wire        lead = sck ^ clock_idle_level;

  // Start values
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
  end

  // Most significant bit goes out as soon as selected
  always @(negedge sel_n) begin
    sh = tx_byte;
    miso = tx_byte[7];
  end

  // Same idle level and phase as the controller
  always @(posedge lead) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge lead) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end

  // A released line must not keep its last level
  always @(posedge sel_n) miso = ~miso;
endmodule

// ### logic/spi_error_control.sv
// Byte-wide serial peripheral interface, controller or target, with
// error flags, low-power handling and a plain register port.
// Assumes pins arrive asynchronously and the bus master never waits.
//
// Chosen here: the plain strobed port and the placing of the registers.
module spi_error_control (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  // Register port
  input  wire spi_error_control_pkg::bus_req_s bus_req,
  output      logic [7:0]                      rdata,
  // Serial pins
  input  wire spi_error_control_pkg::pins_in_s pins_in,
  output spi_error_control_pkg::pins_out_s     pins_out,
  // Power management
  input  wire logic                            halt_mode,
  output      logic                            irq,
  output      logic                            wake
);
  import spi_error_control_pkg::*;

  logic [2:0] sck_s;
  logic [2:0] mosi_s;
  logic [2:0] miso_s;
  logic [2:0] ssn_s;
  logic       sck_lvl_q;
  logic       ssn_lvl_q;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic       done_q;
  logic       write_collision_flag_q;
  logic       ovr_q;
  logic       mode_fault_flag_q;
  logic       sod_q;
  logic       ssm_q;
  logic       ssi_q;
  logic       arm_q;
  logic       mode_fault_flag_arm_q;
  logic [7:0] buf_q;
  logic [7:0] shreg_q;
  logic [7:0] shreg_d;
  logic [7:0] rx_q;
  logic [1:0] smp_q;
  logic [1:0] fin_q;
  logic       out_bit_q;
  logic [4:0] edge_cnt_q;
  logic       busy_q;
  logic [6:0] div_cnt_q;
  logic       halt_q;
  logic       halt_sel_q;
  logic [7:0] rdata_q;
  pins_out_s  pins_q;
  pins_out_s  pins_d;
  logic       irq_q;
  logic       wake_q;

  // Three-stage synchronisers on every pin input
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_s  <= 3'h0;
      mosi_s <= 3'h0;
      miso_s <= 3'h0;
      ssn_s  <= 3'h7;
    end else begin
      sck_s  <= {sck_s[1:0], pins_in.sck};
      mosi_s <= {mosi_s[1:0], pins_in.mosi};
      miso_s <= {miso_s[1:0], pins_in.miso};
      ssn_s  <= {ssn_s[1:0], pins_in.ss_n};
    end
  end

  // A level counts only once the second and third stages agree
  wire sck_agree = sck_s[1] == sck_s[2];
  wire ssn_agree = ssn_s[1] == ssn_s[2];
  wire sck_edge  = sck_agree && (sck_s[2] != sck_lvl_q);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_lvl_q <= 1'b0;
      ssn_lvl_q <= 1'b1;
    end else begin
      sck_lvl_q <= sck_agree ? sck_s[2] : sck_lvl_q;
      ssn_lvl_q <= ssn_agree ? ssn_s[2] : ssn_lvl_q;
    end
  end

  // Control fields
  wire irq_en = ctrl_q[CTRL_IRQ_EN];
  wire pe     = ctrl_q[CTRL_PE];
  wire cs     = ctrl_q[CTRL_CS];
  wire clock_idle_level   = ctrl_q[CTRL_CLOCK_IDLE_LEVEL];
  wire capture_edge_select   = ctrl_q[CTRL_CAPTURE_EDGE_SELECT];
  wire [2:0] rate = {ctrl_q[CTRL_HALVE], ctrl_q[CTRL_RATE_H],
                     ctrl_q[CTRL_RATE_L]};

  // Select level, high means deselected
  wire sel_hi = ssm_q ? ssi_q : ssn_lvl_q;

  // Deep stop lets only a selected target keep shifting
  wire halt_ok = halt_q ? halt_sel_q : ~sel_hi;
  wire run     = ~halt_mode | (halt_ok & ~cs);

  // Register decode; deep stop blocks writes and read side effects, reads still return data
  wire acc    = ~halt_mode;
  wire a_dr   = bus_req.addr == ADDR_DATA;
  wire a_ctrl = bus_req.addr == ADDR_CTRL;
  wire a_csr  = bus_req.addr == ADDR_CSR;
  wire rd_dr  = acc & bus_req.re & a_dr;
  wire wr_dr  = acc & bus_req.we & a_dr;
  wire wr_ctl = acc & bus_req.we & a_ctrl;
  wire rd_csr = acc & bus_req.re & a_csr;
  wire wr_csr = acc & bus_req.we & a_csr;
  wire dr_acc = rd_dr | wr_dr;

  // Transfer engine events
  wire [6:0] half = half_period(rate);
  wire tick     = busy_q & (div_cnt_q == half - 7'h01);
  wire tgt_edge = ~cs & ~sel_hi & sck_edge;
  wire edge_ev  = run & pe & (cs ? tick : tgt_edge);
  wire lead     = ~edge_cnt_q[0];
  wire sample   = edge_ev & (lead ^ capture_edge_select);
  wire shift    = edge_ev & ~(lead ^ capture_edge_select);
  wire complete = edge_ev & (edge_cnt_q == LAST_EDGE);
  wire din      = cs ? miso_s[2] : mosi_s[2];
  wire deselect = ~cs & sel_hi;

  // Controller read-back lags our own clock by the pin synchroniser, so
  // capture and end of byte trail by two cycles; needed at the /4 rate
  wire       cap    = run & smp_q[1];
  wire [7:0] rx_d   = cap ? {rx_q[6:0], miso_s[2]} : rx_q;
  wire       finish = (run & fin_q[1]) | (complete & ~cs);
  wire [7:0] rx_val = fin_q[1] ? rx_d : shreg_d;

  // Writes are held off while done is set and not yet armed
  wire wr_ok   = wr_dr & ~busy_q & ~(done_q & ~arm_q);
  wire wr_coll = wr_dr & busy_q;
  wire mode_fault_flag_ev = run & pe & cs & ~sel_hi;
  wire clr_seq = arm_q & dr_acc;

  // Shift register next value
  always_comb begin
    shreg_d = shreg_q;
    if (wr_ok) begin
      shreg_d = bus_req.wdata;
    end else if (sample) begin
      shreg_d = {shreg_q[6:0], din};
    end
  end

  // Control register next value; a fault beats a write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctl) begin
      ctrl_d = bus_req.wdata;
      if (mode_fault_flag_q & ~mode_fault_flag_arm_q) begin
        ctrl_d[CTRL_PE] = 1'b0;
        ctrl_d[CTRL_CS] = 1'b0;
      end
    end
    if (mode_fault_flag_ev) begin
      ctrl_d[CTRL_PE] = 1'b0;
      ctrl_d[CTRL_CS] = 1'b0;
    end
  end

  // Registers; lower control nibble has no documented reset value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      sod_q  <= CSR_RESET[CSR_SOD];
      ssm_q  <= CSR_RESET[CSR_SSM];
      ssi_q  <= CSR_RESET[CSR_SSI];
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_csr) begin
        sod_q <= bus_req.wdata[CSR_SOD];
        ssm_q <= bus_req.wdata[CSR_SSM];
        ssi_q <= bus_req.wdata[CSR_SSI];
      end
    end
  end

  // Status flags; in every flag the hardware set wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      ovr_q      <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      arm_q      <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else begin
      done_q <= finish | (done_q & ~clr_seq);
      ovr_q  <= (finish & done_q) | (ovr_q & ~rd_csr);
      write_collision_flag_q <= wr_coll | (write_collision_flag_q & ~clr_seq);
      mode_fault_flag_q <= mode_fault_flag_ev | (mode_fault_flag_q & ~(mode_fault_flag_arm_q & wr_ctl));
      if ((rd_csr | wr_csr) & (done_q | write_collision_flag_q)) begin
        arm_q <= 1'b1;
      end else if (dr_acc) begin
        arm_q <= 1'b0;
      end
      if (rd_csr & mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b1;
      end else if (wr_ctl) begin
        mode_fault_flag_arm_q <= 1'b0;
      end
    end
  end

  // Buffer is only refilled when the previous byte was taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buf_q <= BYTE_RESET;
    end else if (finish & ~done_q) begin
      buf_q <= rx_val;
    end
  end

  // Shift register and outgoing bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shreg_q   <= BYTE_RESET;
      out_bit_q <= 1'b0;
      rx_q      <= BYTE_RESET;
      smp_q     <= 2'h0;
      fin_q     <= 2'h0;
    end else begin
      shreg_q <= shreg_d;
      rx_q    <= rx_d;
      if (run) begin
        smp_q <= {smp_q[0], sample & cs};
        fin_q <= {fin_q[0], complete & cs};
      end
      if (wr_ok & ~capture_edge_select) begin
        out_bit_q <= bus_req.wdata[7];
      end else if (shift) begin
        out_bit_q <= shreg_q[7];
      end
    end
  end

  // Edge counter and busy; a target dropped mid-byte starts over
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      edge_cnt_q <= 5'h00;
      busy_q     <= 1'b0;
    end else if (~pe | deselect | complete) begin
      edge_cnt_q <= 5'h00;
      busy_q     <= 1'b0;
    end else if (wr_ok & cs) begin
      edge_cnt_q <= 5'h00;
      busy_q     <= 1'b1;
    end else if (edge_ev) begin
      edge_cnt_q <= edge_cnt_q + 5'h01;
      busy_q     <= 1'b1;
    end
  end

  // Rate divider; frozen while stopped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_q <= 7'h00;
    end else if (~busy_q | ~cs | tick) begin
      div_cnt_q <= 7'h00;
    end else if (run) begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // Select level caught on entry into deep stop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      halt_q     <= 1'b0;
      halt_sel_q <= 1'b0;
    end else begin
      halt_q <= halt_mode;
      if (halt_mode & ~halt_q) begin
        halt_sel_q <= ~sel_hi;
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  wire [7:0] csr_val = {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0,
                        sod_q, ssm_q, ssi_q};
  wire [7:0] rd_mux = a_dr   ? buf_q :
                      a_ctrl ? ctrl_q :
                      a_csr  ? csr_val : 8'h00;

  // Pin drives; clock rests at the idle level between bytes
  wire sck_run = cs & busy_q;
  always_comb begin
    pins_d         = pins_q;
    pins_d.sck_o   = sck_run ? (pins_q.sck_o ^ edge_ev) : clock_idle_level;
    pins_d.sck_oe  = pe & cs;
    pins_d.mosi_o  = out_bit_q;
    pins_d.mosi_oe = pe & cs & ~sod_q;
    pins_d.miso_o  = out_bit_q;
    pins_d.miso_oe = pe & ~cs & ~sel_hi & ~sod_q;
  end

  // Output flops; collision is deliberately left out of the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
      pins_q  <= '0;
      irq_q   <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      rdata_q <= bus_req.re ? rd_mux : 8'h00;
      pins_q  <= pins_d;
      irq_q   <= irq_en & (done_q | mode_fault_flag_q | ovr_q);
      wake_q  <= halt_mode & irq_en & done_q;
    end
  end

  assign rdata    = rdata_q;
  assign pins_out = pins_q;
  assign irq      = irq_q;
  assign wake     = wake_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ovr_set;
    finish && done_q |=> ovr_q;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun not flagged");

  property p_buf_keep;
    finish && done_q |=> $stable(buf_q);
  endproperty
  a_buf_keep: assert property (p_buf_keep)
    else $error("buffer overwritten on overrun");

  property p_ovr_clr;
    rd_csr && !(finish && done_q) |=> !ovr_q;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr)
    else $error("overrun not cleared by status read");

  property p_write_collision_flag;
    wr_dr && busy_q |=> write_collision_flag_q && busy_q;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("collision not flagged or transfer lost");

  property p_irq_src;
    irq_q |-> $past(irq_en && (done_q || mode_fault_flag_q || ovr_q));
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("interrupt without a source");

  property p_done_copy;
    finish && !done_q |=> done_q && buf_q == $past(rx_val);
  endproperty
  a_done_copy: assert property (p_done_copy)
    else $error("received byte not buffered");

  property p_frozen;
    halt_mode && !run |=> $stable(ctrl_q) && $stable(buf_q);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("registers changed in deep stop");

  property p_wake;
    wake_q |-> $past(halt_mode && done_q);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without transfer done");

  property p_mode_fault_flag;
    mode_fault_flag_ev |=> mode_fault_flag_q && !pe && !cs;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag)
    else $error("mode fault not handled");

  property p_idle;
    !sck_run ##1 !sck_run && $stable(clock_idle_level) |-> pins_q.sck_o == clock_idle_level;
  endproperty
  a_idle: assert property (p_idle)
    else $error("clock not at idle level");

  property p_reset_ctrl;
    $past(rst) |-> ctrl_q[7:4] == 4'h0;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("control upper nibble not cleared");

  property p_msb;
    wr_ok && !capture_edge_select |=> out_bit_q == $past(bus_req.wdata[7]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("first bit is not the MSB");

  c_done: cover property (finish && !done_q);
  c_ovr: cover property (finish && done_q);
  c_coll: cover property (wr_dr && busy_q);
  c_wake: cover property (halt_mode && complete);

endmodule

// ### logic/spi_error_control_pkg.sv
// Constants, field layouts and carriers for the serial interface block.
// Assumes a byte-wide register port and pins seen through this package.
package spi_error_control_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_DATA  = 8'h11;
  localparam logic [7:0] IDX_CTRL  = 8'h12;
  localparam logic [7:0] IDX_CSR   = 8'h13;
  localparam logic [7:0] ADDR_DATA = {IDX_DATA[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_CSR  = {IDX_CSR[5:0], 2'b00};

  // Control register fields
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_PE     = 6;
  localparam int CTRL_HALVE  = 5;
  localparam int CTRL_CS     = 4;
  localparam int CTRL_CLOCK_IDLE_LEVEL   = 3;
  localparam int CTRL_CAPTURE_EDGE_SELECT   = 2;
  localparam int CTRL_RATE_H = 1;
  localparam int CTRL_RATE_L = 0;

  // Control/status register fields
  localparam int CSR_DONE = 7;
  localparam int CSR_WRITE_COLLISION_FLAG = 6;
  localparam int CSR_OVR  = 5;
  localparam int CSR_MODE_FAULT_FLAG = 4;
  localparam int CSR_SOD  = 2;
  localparam int CSR_SSM  = 1;
  localparam int CSR_SSI  = 0;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET  = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Sixteen clock transitions make one byte
  localparam logic [4:0] LAST_EDGE = 5'h0f;

  // Half period of the serial clock in system clock cycles
  function automatic logic [6:0] half_period(input logic [2:0] code);
    case (code)
      3'b100:  half_period = 7'h02;
      3'b000:  half_period = 7'h04;
      3'b001:  half_period = 7'h08;
      3'b110:  half_period = 7'h10;
      3'b010:  half_period = 7'h20;
      3'b011:  half_period = 7'h40;
      default: half_period = 7'h04;
    endcase
  endfunction

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } bus_req_s;

  // Pin levels coming in
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } pins_in_s;

  // Pin drives going out
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } pins_out_s;

endpackage
